/* File: src/serial_link_transmit_encoder.sv */
`timescale 1ns/1ps
`include "tx_link_defines.svh"
module serial_link_transmit_encoder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AXI4-Lite register port
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Host-side parallel pins
  input  wire logic        byte_clock_in,
  input  wire logic        load_now_n,
  input  wire logic        load_next_n,
  input  wire logic [7:0]  byte_in,
  input  wire logic        special_char_select,
  input  wire logic        force_violation,
  input  wire logic [9:0]  raw_symbol_in,
  // Serial outputs and FIFO read strobe
  output logic             serial_out_first,
  output logic             serial_out_second,
  output logic             serial_out_loopback,
  output logic             fifo_read_pulse_n
);
  import tx_link_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [22:0] pin_raw;
  logic [22:0] meta_q;
  logic [22:0] sync_q;
  logic        ckw_s;
  logic        now_n_s;
  logic        next_n_s;
  char_t       pin_char;
  logic [9:0]  raw_s;

  assign pin_raw = {byte_clock_in, load_now_n, load_next_n,
                    byte_in, special_char_select, force_violation,
                    raw_symbol_in};

  // All pins take the same two stages, so a byte stays coherent.
  always_ff @(posedge clk) begin
    meta_q <= pin_raw;
    sync_q <= meta_q;
  end

  assign ckw_s    = sync_q[22];
  assign now_n_s  = sync_q[21];
  assign next_n_s = sync_q[20];
  assign pin_char = sync_q[19:10];
  assign raw_s    = sync_q[9:0];

  // ----------------------------------------------------------------------
  // Input register and self-test generator
  // ----------------------------------------------------------------------
  logic        ckw_prev_q;
  logic        ckw_rise;
  load_state_t load_state_q, load_state_d;
  char_t       hold_q, hold_d;
  logic [9:0]  raw_q, raw_d;
  logic        filled_q, filled_d;
  logic [8:0]  lfsr_q, lfsr_d;
  logic        bypass_q, bypass_d;
  logic        off_q, off_d;
  logic        self_test_n_q, self_test_n_d;
  logic        byte_tick;

  assign ckw_rise = ckw_s & ~ckw_prev_q;

  // A load after the transfer clear wins, so no byte is dropped.
  always_comb begin
    load_state_d = load_state_q;
    hold_d       = hold_q;
    raw_d        = raw_q;
    filled_d     = filled_q;
    lfsr_d       = self_test_n_q ? `LFSR_SEED : lfsr_q;
    if (byte_tick) begin
      filled_d = 1'b0;
    end
    if (ckw_rise) begin
      if (!self_test_n_q) begin
        lfsr_d   = {lfsr_q[7:0], lfsr_q[8] ^ lfsr_q[4]};
        hold_d   = '{data: lfsr_q[7:0], special: lfsr_q[8],
                     violation: lfsr_q == `LFSR_SEED};
        filled_d = 1'b1;
      end else if (!now_n_s || load_state_q == LOAD_NEXT) begin
        hold_d   = pin_char;
        raw_d    = raw_s;
        filled_d = 1'b1;
      end else begin
        filled_d = 1'b0;
      end
      load_state_d = next_n_s ? LOAD_IDLE : LOAD_NEXT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ckw_prev_q   <= 1'b0;
      load_state_q <= LOAD_IDLE;
      hold_q       <= '0;
      raw_q        <= 10'h000;
      filled_q     <= 1'b0;
      lfsr_q       <= `LFSR_SEED;
    end else begin
      ckw_prev_q   <= ckw_s;
      load_state_q <= load_state_d;
      hold_q       <= hold_d;
      raw_q        <= raw_d;
      filled_q     <= filled_d;
      lfsr_q       <= lfsr_d;
    end
  end

  // ----------------------------------------------------------------------
  // Encoder, shifter and outputs
  // ----------------------------------------------------------------------
  logic [3:0]  bit_cnt_q, bit_cnt_d;
  logic [9:0]  shift_q, shift_d;
  logic        rd_q, rd_d;
  char_t       enc_in;
  logic [9:0]  enc_sym;
  logic        enc_rd;
  logic        out_a_d, out_b_d, out_c_d, rp_n_d;

  assign byte_tick = (bit_cnt_q == `BIT_LAST);
  assign enc_in    = filled_q ? hold_q :
                     '{data: `K28_5_BYTE, special: 1'b1, violation: 1'b0};

  symbol_encoder u_encoder (
    .ch     (enc_in),
    .rd_in  (rd_q),
    .symbol (enc_sym),
    .rd_out (enc_rd)
  );

  // Bit a sits in bit 9 and leaves first; the word reloads on bit nine.
  always_comb begin
    bit_cnt_d = byte_tick ? 4'h0 : 4'(bit_cnt_q + 4'h1);
    shift_d   = {shift_q[8:0], 1'b0};
    rd_d      = rd_q;
    if (byte_tick) begin
      if (bypass_q) begin
        shift_d = filled_q ? raw_q : `K28_5_RDN;
      end else begin
        shift_d = enc_sym;
        rd_d    = enc_rd;
      end
    end
    out_a_d = shift_q[9] & ~off_q;
    out_b_d = shift_q[9] & ~off_q;
    out_c_d = shift_q[9];
    rp_n_d  = (bit_cnt_d >= `RP_LOW_BITS);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_q           <= 4'h0;
      shift_q             <= 10'h000;
      rd_q                <= 1'b0;
      serial_out_first    <= 1'b0;
      serial_out_second   <= 1'b0;
      serial_out_loopback <= 1'b0;
      fifo_read_pulse_n   <= 1'b1;
    end else begin
      bit_cnt_q           <= bit_cnt_d;
      shift_q             <= shift_d;
      rd_q                <= rd_d;
      serial_out_first    <= out_a_d;
      serial_out_second   <= out_b_d;
      serial_out_loopback <= out_c_d;
      fifo_read_pulse_n   <= rp_n_d;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [2:0]  w_bits_q, w_bits_d;
  logic        w_lane0_q, w_lane0_d;
  logic        bvalid_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic        wr_fire;

  // Address and data are parked separately, so either may come first.
  assign wr_fire = aw_have_q & w_have_q & ~bvalid;

  always_comb begin
    aw_have_d     = aw_have_q;
    aw_addr_d     = aw_addr_q;
    w_have_d      = w_have_q;
    w_bits_d      = w_bits_q;
    w_lane0_d     = w_lane0_q;
    bvalid_d      = bvalid & ~bready;
    bresp_d       = bresp;
    rvalid_d      = rvalid & ~rready;
    rresp_d       = rresp;
    rdata_d       = rdata;
    bypass_d      = bypass_q;
    off_d         = off_q;
    self_test_n_d = self_test_n_q;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_have_d  = 1'b1;
      w_bits_d  = wdata[2:0];
      w_lane0_d = wstrb[0];
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `RESP_SLVERR;
      if (aw_addr_q == `CTRL_ADDR) begin
        bresp_d = `RESP_OKAY;
        if (w_lane0_q) begin
          bypass_d      = w_bits_q[`CTRL_BYPASS_BIT];
          off_d         = w_bits_q[`CTRL_OPT_OFF_BIT];
          self_test_n_d = w_bits_q[`CTRL_SELF_TEST_N_BIT];
        end
      end
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (araddr == `CTRL_ADDR) begin
        rdata_d[`CTRL_BYPASS_BIT]      = bypass_q;
        rdata_d[`CTRL_OPT_OFF_BIT]     = off_q;
        rdata_d[`CTRL_SELF_TEST_N_BIT] = self_test_n_q;
      end else if (araddr == `STATUS_ADDR) begin
        rdata_d[`STATUS_RD_BIT]     = rd_q;
        rdata_d[`STATUS_FILLED_BIT] = filled_q;
        rdata_d[`STATUS_LFSR_LSB +: 9] = lfsr_q;
      end else begin
        rresp_d = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_have_q      <= 1'b0;
      w_bits_q      <= 3'h0;
      w_lane0_q     <= 1'b0;
      awready       <= 1'b0;
      wready        <= 1'b0;
      arready       <= 1'b0;
      bvalid        <= 1'b0;
      bresp         <= `RESP_OKAY;
      rvalid        <= 1'b0;
      rresp         <= `RESP_OKAY;
      rdata         <= 32'h0000_0000;
      {self_test_n_q, off_q, bypass_q} <= `CTRL_RESET;
    end else begin
      aw_have_q     <= aw_have_d;
      aw_addr_q     <= aw_addr_d;
      w_have_q      <= w_have_d;
      w_bits_q      <= w_bits_d;
      w_lane0_q     <= w_lane0_d;
      awready       <= ~aw_have_d;
      wready        <= ~w_have_d;
      arready       <= ~rvalid_d;
      bvalid        <= bvalid_d;
      bresp         <= bresp_d;
      rvalid        <= rvalid_d;
      rresp         <= rresp_d;
      rdata         <= rdata_d;
      bypass_q      <= bypass_d;
      off_q         <= off_d;
      self_test_n_q <= self_test_n_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_strobe_low;
    !fifo_read_pulse_n [*5];
  endsequence

  property p_byte_period;
    byte_tick |-> ##10 byte_tick;
  endproperty
  a_byte_period: assert property (p_byte_period)
    else $error("byte transfer period is not ten bits");
  property p_read_pulse;
    byte_tick |=> s_strobe_low ##1 fifo_read_pulse_n;
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read strobe width wrong");
  property p_light_off;
    off_q |=> (!serial_out_first && !serial_out_second);
  endproperty
  a_light_off: assert property (p_light_off)
    else $error("gated output high while off");
  property p_same_stream;
    !off_q |=> (serial_out_first == serial_out_loopback &&
                serial_out_second == serial_out_loopback);
  endproperty
  a_same_stream: assert property (p_same_stream)
    else $error("serial outputs differ");
  property p_comma_fill;
    byte_tick && !filled_q |=>
      (shift_q == `K28_5_RDN || shift_q == ~`K28_5_RDN);
  endproperty
  a_comma_fill: assert property (p_comma_fill)
    else $error("no comma sent for empty byte time");
  property p_load_now;
    ckw_rise && !now_n_s && self_test_n_q |=>
      filled_q && hold_q == $past(pin_char);
  endproperty
  a_load_now: assert property (p_load_now)
    else $error("load-now did not capture inputs");
  property p_load_next;
    ckw_rise && !next_n_s |=> load_state_q == LOAD_NEXT;
  endproperty
  a_load_next: assert property (p_load_next)
    else $error("load-next not armed");
  property p_bypass;
    byte_tick && bypass_q && filled_q |=> shift_q == $past(raw_q);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("raw word not passed in bypass");
endmodule

/* File: src/symbol_encoder.sv */
`timescale 1ns/1ps
`include "tx_link_defines.svh"
module symbol_encoder (
  // Character in and running disparity, 1 means positive
  input  wire tx_link_pkg::char_t ch,
  input  wire logic               rd_in,
  // Symbol, bit 9 is bit a, and disparity after it
  output logic [9:0]              symbol,
  output logic                    rd_out
);
  import tx_link_pkg::*;

  // ----------------------------------------------------------------------
  // Code tables, negative-disparity forms
  // ----------------------------------------------------------------------
  localparam logic [5:0] SIX [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] FOUR_D [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  localparam logic [3:0] FOUR_K [8] = '{
    4'hb, 4'h6, 4'ha, 4'hc, 4'hd, 4'h5, 4'h9, 4'h7};
  localparam logic [5:0] SIX_K28  = 6'h0f;
  localparam logic [5:0] SIX_D7   = 6'h38;
  localparam logic [3:0] FOUR_ALT = 4'h7;
  localparam logic [3:0] FOUR_X3  = 4'hc;

  function automatic logic [2:0] count_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction

  logic [4:0] x5;
  logic [2:0] y3;
  logic [5:0] six;
  logic [3:0] four;
  logic       rd6;
  logic       alt7;

  // Both sub-blocks pick their polarity from the disparity before them.
  always_comb begin
    x5 = ch.data[4:0];
    y3 = ch.data[7:5];
    six = (ch.special && x5 == 5'h1c) ? SIX_K28 : SIX[x5];
    if (rd_in && (count_ones(six) != 3'h3 || six == SIX_D7)) begin
      six = ~six;
    end
    rd6 = (count_ones(six) != 3'h3) ? ~rd_in : rd_in;
    // Alternate x.7 avoids a run of five equal bits across the join.
    alt7 = (y3 == 3'h7) &&
           ((!rd6 && (x5 == 5'h11 || x5 == 5'h12 || x5 == 5'h14)) ||
            (rd6 && (x5 == 5'h0b || x5 == 5'h0d || x5 == 5'h0e)));
    four = ch.special ? FOUR_K[y3] : (alt7 ? FOUR_ALT : FOUR_D[y3]);
    // The special table holds forms for a negative six-bit end, so every
    // special four-bit block flips after a positive one, balanced or not.
    if (rd6 && (ch.special || count_ones({2'h0, four}) != 3'h2 ||
                four == FOUR_X3)) begin
      four = ~four;
    end
    rd_out = (count_ones({2'h0, four}) != 3'h2) ? ~rd6 : rd6;
    symbol = {six, four};
    if (ch.violation) begin
      symbol = rd_in ? ~`VIOL_RDN : `VIOL_RDN;
      rd_out = rd_in;
    end
  end
endmodule

/* File: src/tx_link_defines.svh */
`ifndef TX_LINK_DEFINES_SVH
`define TX_LINK_DEFINES_SVH
// Operation
// - Each byte-clock rising edge can capture data, special select, force-violation.
// - Load-now low at an edge loads the inputs present at that edge.
// - Load-next low at an edge loads the inputs at the following edge.
// - With neither enable low, the byte time sends the K28.5 comma.
// - Self-test turns the input register into a 511-byte LFSR source.
// - Special select high encodes the byte with the special-code table.
// - Special select low encodes the byte with the data-code table.
// - Force-violation sends a fixed violation symbol instead of the character.
// - Bypass mode sends ten raw bits a..j straight to the shifter.
// - In bypass mode raw bit a leaves first, then letter order.
// - Shifter takes one 10-bit word per byte time, ten bits out.
// - Word transfer timing comes only from the internal bit counter.
// - All three serial outputs carry the same shifter stream.
// - Optical-off forces the first and second outputs to zero.
// - The loopback output ignores optical-off and keeps streaming.
// - Optical-off acts within bit times, not aligned to characters.
// - Active-low byte-rate read pulse from the bit counter, fixed width.

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CTRL_ADDR            8'h00
`define STATUS_ADDR          8'h04
`define CTRL_BYPASS_BIT      0
`define CTRL_OPT_OFF_BIT     1
`define CTRL_SELF_TEST_N_BIT 2
`define CTRL_RESET           3'h4
`define STATUS_RD_BIT        0
`define STATUS_FILLED_BIT    1
`define STATUS_LFSR_LSB      2
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

// ----------------------------------------------------------------------
// Timing and codes
// ----------------------------------------------------------------------
`define BIT_LAST             4'h9
`define RP_LOW_BITS          4'h5
`define K28_5_BYTE           8'hbc
`define K28_5_RDN            10'h0fa
`define VIOL_RDN             10'h278
`define LFSR_SEED            9'h1ff
`endif

/* File: src/tx_link_pkg.sv */
package tx_link_pkg;
  // One character held by the input register.
  typedef struct packed {
    logic [7:0] data;
    logic       special;
    logic       violation;
  } char_t;

  // Whether a load-next request is waiting for the next edge.
  typedef enum logic {LOAD_IDLE, LOAD_NEXT} load_state_t;
endpackage

/* File: verification/host_fifo_model.sv */
`timescale 1ns/1ps
module host_fifo_model (
  // Parallel pins toward the transmitter
  output logic       byte_clock_in,
  output logic       load_now_n,
  output logic       load_next_n,
  output logic [7:0] byte_in,
  output logic       special_char_select,
  output logic       force_violation,
  output logic [9:0] raw_symbol_in
);
  // Queued byte times: {now_n, next_n, special, violation, byte, raw}.
  logic [21:0] plan_q[$];
  logic [21:0] cur;

  // Byte clock of 400 ns, its phase unrelated to the bit clock.
  initial begin
    byte_clock_in = 1'b0;
    {load_now_n, load_next_n} = 2'b11;
    {special_char_select, force_violation} = 2'b00;
    byte_in = 8'h00;
    raw_symbol_in = 10'h000;
    #13;
    forever #200 byte_clock_in = ~byte_clock_in;
  end

  // Pins change mid-byte, so every rising edge sees settled values.
  // enables held across edge
  always @(negedge byte_clock_in) begin
    if (plan_q.size() > 0) begin
      cur = plan_q.pop_front();
      {load_now_n, load_next_n} <= cur[21:20];
      {special_char_select, force_violation} <= cur[19:18];
      byte_in <= cur[17:10];
      raw_symbol_in <= cur[9:0];
    end else begin
      // Idle lines stop showing the last value on purpose.
      {load_now_n, load_next_n} <= 2'b11;
      special_char_select <= ~special_char_select;
      force_violation <= ~force_violation;
      byte_in <= ~byte_in;
      raw_symbol_in <= ~raw_symbol_in;
    end
  end
endmodule

/* File: verification/serial_link_transmit_encoder_bench.sv */
`timescale 1ns/1ps
`include "tx_link_defines.svh"
module serial_link_transmit_encoder_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  awaddr, araddr, byte_in;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, ph, off;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rp_q;
  logic        byte_clock_in, load_now_n, load_next_n;
  logic        special_char_select, force_violation;
  logic [9:0]  raw_symbol_in, sh;
  logic        serial_out_first, serial_out_second;
  logic        serial_out_loopback, fifo_read_pulse_n;
  logic [9:0]  words[$];
  int          num_errors, total_checks;

  serial_link_transmit_encoder serial_link_transmit_encoder_inst (
    .clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .byte_clock_in, .load_now_n,
    .load_next_n, .byte_in, .special_char_select, .force_violation,
    .raw_symbol_in, .serial_out_first, .serial_out_second,
    .serial_out_loopback, .fifo_read_pulse_n);

  host_fifo_model host_fifo_model_inst (
    .byte_clock_in, .load_now_n, .load_next_n, .byte_in,
    .special_char_select, .force_violation, .raw_symbol_in);

  // 25 MHz bit clock.
  always #20 clk = ~clk;

  // Words are framed by the read strobe; off is found once by t_bypass.
  always @(posedge clk) begin
    rp_q <= fifo_read_pulse_n;
    ph <= (rp_q && !fifo_read_pulse_n) ? 4'h0 : ph + 4'h1;
    sh <= {sh[8:0], serial_out_loopback};
    if (ph == off)
      words.push_back({sh[8:0], serial_out_loopback});
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One clock with a bound, so no handshake wait can hang the run.
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 300) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic aw_p, w_p;
    int   n;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p) begin
      tick(n);
      if (aw_p && awready) awvalid <= 1'b0;
      if (w_p && wready) wvalid <= 1'b0;
      aw_p = aw_p && !awready;
      w_p = w_p && !wready;
    end
    while (!bvalid) tick(n);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, r});
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tick(n);
    while (!arready) tick(n);
    arvalid <= 1'b0;
    while (!rvalid) tick(n);
    rready <= 1'b0;
    d = rdata;
    chk({30'h0, rresp}, {30'h0, r});
  endtask

  task automatic put(input logic [21:0] e, input int k);
    repeat (k) host_fifo_model_inst.plan_q.push_back(e);
  endtask

  task automatic collect(input int bytes);
    words.delete();
    repeat (bytes * 10) @(posedge clk);
  endtask

  // Either disparity form of a symbol counts.
  function automatic int cnt(input logic [9:0] w);
    int c;
    c = 0;
    foreach (words[i])
      if (words[i] === w || words[i] === ~w) c++;
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    axi_rd(`CTRL_ADDR, d, `RESP_OKAY);
    chk(d & 32'h7, {29'h0, `CTRL_RESET});
    axi_rd(8'h08, d, `RESP_SLVERR);
    chk(d, 32'h0);
    axi_wr(`STATUS_ADDR, 32'h7, `RESP_SLVERR);
  endtask

  // Read strobe must be low five cycles of every ten.
  task automatic t_pulse();
    int lows;
    repeat (3) begin
      lows = 0;
      repeat (10) begin
        @(posedge clk);
        lows += int'(!fifo_read_pulse_n);
      end
      chk(lows, 5);
    end
  endtask

  // Bypass: idle commas frame the stream, then raw words pass through.
  task automatic t_bypass();
    logic [19:0] s;
    int          n;
    n = 0;
    axi_wr(`CTRL_ADDR, 32'h5, `RESP_OKAY);
    repeat (40) @(posedge clk);
    while (ph != 4'h0) tick(n);
    for (int i = 0; i < 20; i++) begin
      s[19 - i] = serial_out_loopback;
      @(posedge clk);
    end
    off = 4'hf;
    for (int k = 0; k < 10; k++)
      if (s[19 - k -: 10] === `K28_5_RDN) off = 4'((k + 9) % 10);
    chk({31'h0, off != 4'hf}, 32'h1);
    put({4'b0100, 8'h00, 10'h2d3}, 12);
    repeat (30) @(posedge clk);
    collect(8);
    chk({31'h0, cnt(10'h2d3) >= 7}, 32'h1);
    axi_wr(`CTRL_ADDR, 32'h4, `RESP_OKAY);
    repeat (40) @(posedge clk);
  endtask

  // Idle in coded mode sends commas of alternating disparity.
  task automatic t_idle();
    collect(8);
    chk(cnt(`K28_5_RDN), words.size());
    for (int i = 1; i < words.size(); i++)
      chk({22'h0, words[i] ^ words[i - 1]}, 32'h3ff);
  endtask

  task automatic steady(input logic sc, input logic sv,
                        input logic [7:0] b, input logic [9:0] w);
    put({2'b01, sc, sv, b, 10'h000}, 12);
    repeat (30) @(posedge clk);
    collect(8);
    chk({31'h0, cnt(w) >= 7}, 32'h1);
    repeat (20) @(posedge clk);
  endtask

  // A single load-next or load-now byte among idle bytes.
  task automatic t_load(input logic [1:0] en);
    put({en, 2'b00, 8'h00, 10'h000}, 1);
    put({2'b11, 2'b00, 8'hb5, 10'h000}, 1);
    collect(8);
    chk(cnt(10'h2aa), en[1] ? 32'h1 : 32'h0);
    chk(cnt(10'h274), en[1] ? 32'h0 : 32'h1);
  endtask

  task automatic gate(input logic dark);
    int ones;
    ones = 0;
    axi_wr(`CTRL_ADDR, {29'h0, 1'b1, dark, 1'b0}, `RESP_OKAY);
    repeat (3) @(posedge clk);
    repeat (30) begin
      @(posedge clk);
      ones += int'(serial_out_loopback);
      chk({31'h0, serial_out_first}, {31'h0, serial_out_loopback & !dark});
      chk({31'h0, serial_out_second}, {31'h0, serial_out_loopback & !dark});
    end
    chk({31'h0, ones > 0 && ones < 30}, 32'h1);
  endtask

  task automatic lfsr_at(output logic [8:0] v);
    logic [31:0] d;
    @(posedge byte_clock_in);
    repeat (5) @(posedge clk);
    axi_rd(`STATUS_ADDR, d, `RESP_OKAY);
    v = d[10:2];
  endtask

  task automatic t_selftest();
    logic [8:0] l0, l1, l2;
    axi_wr(`CTRL_ADDR, 32'h0, `RESP_OKAY);
    lfsr_at(l0);
    lfsr_at(l1);
    chk({31'h0, l1 !== l0}, 32'h1);
    repeat (509) @(posedge byte_clock_in);
    lfsr_at(l2);
    chk({23'h0, l2}, {23'h0, l0});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {ph, off, rp_q, sh} = '0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_pulse();
    t_bypass();
    t_idle();
    steady(1'b0, 1'b0, 8'hb5, 10'h2aa);
    steady(1'b1, 1'b0, 8'hfc, 10'h0f8);
    steady(1'b0, 1'b1, 8'hb5, `VIOL_RDN);
    t_load(2'b10);
    t_load(2'b01);
    gate(1'b0);
    gate(1'b1);
    t_selftest();
    wrap_up();
  end
endmodule
